/* rtl/xal_pkg.sv */
// Constants and types shared by the extended ALU and address datapath
//------------------------------------------------------------------------------
// Summary of operation
//------------------------------------------------------------------------------
// Summary of operation
// - Subtract with carry: dst plus inverted src plus C
// - Subtract flags: N, Z, carry, signed overflow
// - Register byte swap; address-word keeps top, word clears
// - Memory byte swap; address-word clears bits 31:20
// - Byte swap leaves all four flags alone
// - Register sign extend fills bits 19:8 always
// - Memory sign extend: address-word 19:8, word 15:8
// - Sign extend flags: N, Z, C=not Z, V=0
// - Test against zero; destination kept, C=1, V=0
// - Exclusive OR into destination, source unchanged
// - Exclusive OR flags; V when both operands negative
// - Address ops: register or immediate; move has more (here add also takes every memory source mode)
// - 20-bit register add with 20-bit flags
// - Jump loads 20-bit target; memory words low first
// - Auto-increment jump pointer grows by four
// - Symbolic and indexed use signed 16-bit index
// - Oscillator, processor-off, interrupt-enable bits untouched
package xal_pkg;

    // Operation codes
    localparam logic [3:0] OP_SUBC = 4'h0;
    localparam logic [3:0] OP_SWPB = 4'h1;
    localparam logic [3:0] OP_SXT  = 4'h2;
    localparam logic [3:0] OP_TST  = 4'h3;
    localparam logic [3:0] OP_XOR  = 4'h4;
    localparam logic [3:0] OP_WADD = 4'h5;
    localparam logic [3:0] OP_JMP  = 4'h6;
    localparam logic [3:0] OP_WMOV = 4'h7;

    // Operand sizes
    localparam logic [1:0] SZ_ADDR = 2'h0;
    localparam logic [1:0] SZ_WORD = 2'h1;
    localparam logic [1:0] SZ_BYTE = 2'h2;

    // Addressing modes
    localparam logic [2:0] M_REG = 3'h0;
    localparam logic [2:0] M_IMM = 3'h1;
    localparam logic [2:0] M_SYM = 3'h2;
    localparam logic [2:0] M_ABS = 3'h3;
    localparam logic [2:0] M_IND = 3'h4;
    localparam logic [2:0] M_INC = 3'h5;
    localparam logic [2:0] M_IDX = 3'h6;

    // Special register numbers
    localparam logic [3:0] REG_PC = 4'h0;
    localparam logic [3:0] REG_SR = 4'h2;
    localparam logic [3:0] REG_CG = 4'h3;

    // Status register bit positions and reset value
    localparam int SR_C      = 0;
    localparam int SR_Z      = 1;
    localparam int SR_N      = 2;
    localparam int SR_IEN    = 3;
    localparam int SR_PRCOFF = 4;
    localparam int SR_OSCSTP = 5;
    localparam int SR_V      = 8;
    localparam logic [15:0] SR_RESET = 16'h0000;
    localparam logic [19:0] PC_RESET = 20'h00000;

    // Address step to the high word, and pointer steps per size
    localparam logic [19:0] HI_WORD_STEP = 20'h00002;
    localparam logic [19:0] STEP_ADDR    = 20'h00004;
    localparam logic [19:0] STEP_WORD    = 20'h00002;
    localparam logic [19:0] STEP_BYTE    = 20'h00001;

    typedef enum logic [9:0] {
        ST_IDLE  = 10'b0000000001,
        ST_RDREG = 10'b0000000010,
        ST_SRCLO = 10'b0000000100,
        ST_SRCHI = 10'b0000001000,
        ST_DSTGO = 10'b0000010000,
        ST_DSTLO = 10'b0000100000,
        ST_DSTHI = 10'b0001000000,
        ST_EXEC  = 10'b0010000000,
        ST_WRLO  = 10'b0100000000,
        ST_WRHI  = 10'b1000000000
    } xal_state_t;

    typedef struct packed {
        xal_state_t  state;
        logic [3:0]  op;
        logic [1:0]  size;
        logic [2:0]  smode;
        logic [2:0]  dmode;
        logic [3:0]  sreg;
        logic [3:0]  dreg;
        logic [19:0] simm;
        logic [15:0] sidx;
        logic [19:0] dimm;
        logic [15:0] didx;
        logic [19:0] src;
        logic [19:0] dst;
        logic [19:0] daddr;
        logic [19:0] res;
        logic [19:0] pc;
        logic [15:0] sr;
        logic        rf_we;
        logic [3:0]  rf_waddr;
        logic [19:0] rf_wdata;
        logic        mem_req;
        logic        mem_we;
        logic        mem_byte;
        logic [19:0] mem_addr;
        logic [15:0] mem_wdata;
        logic        ready;
        logic        done;
    } xal_core_t;

endpackage : xal_pkg

/* rtl/xal_regfile.sv */
// Working register file with two registered read ports
`timescale 1ns/1ns
`default_nettype none
module xal_regfile
#(
    parameter int WIDTH = 20,
    parameter int DEPTH = 16
)
(
    input  wire logic                     clk,
    input  wire logic [$clog2(DEPTH)-1:0] raddr_a,
    input  wire logic [$clog2(DEPTH)-1:0] raddr_b,
    output logic      [WIDTH-1:0]         rdata_a,
    output logic      [WIDTH-1:0]         rdata_b,
    input  wire logic                     we,
    input  wire logic [$clog2(DEPTH)-1:0] waddr,
    input  wire logic [WIDTH-1:0]         wdata
);

    logic [WIDTH-1:0] mem [DEPTH];

    //--------------------------------------------------------------------------
    // Storage and read registers
    //--------------------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (we)
        begin
            mem[waddr] <= wdata;
        end
        rdata_a <= (we && waddr == raddr_a) ? wdata : mem[raddr_a];
        rdata_b <= (we && waddr == raddr_b) ? wdata : mem[raddr_b];
    end

endmodule // xal_regfile
`default_nettype wire

/* rtl/xal_core.sv */
// Execution datapath for extended 20-bit arithmetic, swap, extend and jump operations
`timescale 1ns/1ns
`default_nettype none
module xal_core
    import xal_pkg::*;
(
    input  wire logic        REF_CLK,
    input  wire logic        RST_N,
    input  wire logic        OP_VALID,
    input  wire logic [3:0]  OP_CODE,
    input  wire logic [1:0]  OP_SIZE,
    input  wire logic [2:0]  SRC_MODE,
    input  wire logic [3:0]  SRC_REG,
    input  wire logic [19:0] SRC_IMM,
    input  wire logic [15:0] SRC_INDEX,
    input  wire logic [2:0]  DST_MODE,
    input  wire logic [3:0]  DST_REG,
    input  wire logic [19:0] DST_IMM,
    input  wire logic [15:0] DST_INDEX,
    output logic             OP_READY,
    output logic             OP_DONE,
    output logic [19:0]      RESULT,
    output logic [19:0]      PC_VALUE,
    output logic [15:0]      STATUS_REG,
    output logic             MEM_REQ,
    output logic             MEM_WE,
    output logic             MEM_BYTE,
    output logic [19:0]      MEM_ADDR,
    output logic [15:0]      MEM_WDATA,
    input  wire logic        MEM_ACK,
    input  wire logic [15:0] MEM_RDATA
);

    //--------------------------------------------------------------------------
    // Helper functions
    //--------------------------------------------------------------------------
    function automatic logic [19:0] width_mask(input logic [1:0] sz);
        width_mask = (sz == SZ_ADDR) ? 20'hfffff : (sz == SZ_WORD) ? 20'h0ffff : 20'h000ff;
    endfunction

    function automatic logic msb_of(input logic [19:0] v, input logic [1:0] sz);
        msb_of = (sz == SZ_ADDR) ? v[19] : (sz == SZ_WORD) ? v[15] : v[7];
    endfunction

    function automatic logic carry_of(input logic [20:0] s, input logic [1:0] sz);
        carry_of = (sz == SZ_ADDR) ? s[20] : (sz == SZ_WORD) ? s[16] : s[8];
    endfunction

    function automatic logic [19:0] reg_view(input logic [3:0] sel, input logic [19:0] rf,
                                             input logic [19:0] pc, input logic [15:0] sr);
        if (sel == REG_PC)
            reg_view = pc;
        else if (sel == REG_SR)
            reg_view = {4'h0, sr};
        else if (sel == REG_CG)
            reg_view = 20'h00000;
        else
            reg_view = rf;
    endfunction

    function automatic logic [19:0] addr_of(input logic [2:0] md, input logic [19:0] base,
                                            input logic [19:0] pc, input logic [15:0] idx,
                                            input logic [19:0] imm);
        logic [19:0] sidx;
        sidx = {{4{idx[15]}}, idx};
        unique case (md)
            M_SYM:   addr_of = pc + sidx;
            M_ABS:   addr_of = imm;
            M_IDX:   addr_of = base + sidx;
            default: addr_of = base;
        endcase
    endfunction

    function automatic logic [19:0] step_of(input logic [1:0] sz);
        step_of = (sz == SZ_ADDR) ? STEP_ADDR : (sz == SZ_WORD) ? STEP_WORD : STEP_BYTE;
    endfunction

    //--------------------------------------------------------------------------
    // Reset release
    //--------------------------------------------------------------------------
    logic rst_meta_n;
    logic rst_n;

    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            rst_meta_n <= 1'b0;
            rst_n      <= 1'b0;
        end
        else
        begin
            rst_meta_n <= 1'b1;
            rst_n      <= rst_meta_n;
        end
    end

    //--------------------------------------------------------------------------
    // Register file
    //--------------------------------------------------------------------------
    xal_core_t   q;
    xal_core_t   n;
    logic [19:0] rd_a;
    logic [19:0] rd_b;
    logic [3:0]  ra;
    logic [3:0]  rb;

    assign ra = q.state == ST_IDLE ? SRC_REG : q.sreg;
    assign rb = q.state == ST_IDLE ? DST_REG : q.dreg;

    xal_regfile #(.WIDTH(20), .DEPTH(16)) u_regs
    (
        .clk     (REF_CLK),
        .raddr_a (ra),
        .raddr_b (rb),
        .rdata_a (rd_a),
        .rdata_b (rd_b),
        .we      (q.rf_we),
        .waddr   (q.rf_waddr),
        .wdata   (q.rf_wdata)
    );

    //--------------------------------------------------------------------------
    // Sequencer and datapath
    //--------------------------------------------------------------------------
    always_comb
    begin
        logic [19:0] s_base;
        logic [19:0] d_base;
        logic [19:0] saddr;
        logic [19:0] m;
        logic [19:0] r;
        logic [20:0] sum;
        logic        fc;
        logic        fv;
        logic        upd;
        logic        has_src;
        logic        wr_dst;
        s_base  = reg_view(q.sreg, rd_a, q.pc, q.sr);
        d_base  = reg_view(q.dreg, rd_b, q.pc, q.sr);
        saddr   = addr_of(q.smode, s_base, q.pc, q.sidx, q.simm);
        m       = width_mask(q.size);
        r       = 20'h00000;
        sum     = 21'h000000;
        fc      = 1'b0;
        fv      = 1'b0;
        upd     = 1'b0;
        has_src = q.op == OP_SUBC || q.op == OP_XOR || q.op == OP_WADD || q.op == OP_JMP || q.op == OP_WMOV;
        wr_dst  = q.op != OP_TST && q.op != OP_JMP;
        n       = q;
        n.done  = 1'b0;
        n.rf_we = 1'b0;
        unique case (q.state)
            ST_IDLE:
            begin
                if (OP_VALID)
                begin
                    n.op    = OP_CODE;
                    n.size  = (OP_CODE == OP_WADD || OP_CODE == OP_JMP || OP_CODE == OP_WMOV) ? SZ_ADDR : OP_SIZE;
                    n.smode = SRC_MODE;
                    n.sreg  = SRC_REG;
                    n.simm  = SRC_IMM;
                    n.sidx  = SRC_INDEX;
                    // Address ops always target a register
                    n.dmode = (OP_CODE == OP_WADD || OP_CODE == OP_WMOV) ? M_REG : DST_MODE;
                    n.dreg  = DST_REG;
                    n.dimm  = DST_IMM;
                    n.didx  = DST_INDEX;
                    n.ready = 1'b0;
                    n.state = ST_RDREG;
                end
            end
            ST_RDREG:
            begin
                n.daddr = addr_of(q.dmode, d_base, q.pc, q.didx, q.dimm);
                if (!has_src)
                    n.state = ST_DSTGO;
                else if (q.smode == M_REG)
                begin
                    n.src   = s_base & m;
                    n.state = ST_DSTGO;
                end
                else if (q.smode == M_IMM)
                begin
                    n.src   = q.simm & m;
                    n.state = ST_DSTGO;
                end
                else
                begin
                    n.mem_req  = 1'b1;
                    n.mem_we   = 1'b0;
                    n.mem_byte = q.size == SZ_BYTE;
                    n.mem_addr = saddr;
                    n.state    = ST_SRCLO;
                end
            end
            ST_SRCLO:
            begin
                if (MEM_ACK)
                begin
                    n.src     = {4'h0, MEM_RDATA} & m;
                    n.mem_req = 1'b0;
                    if (q.size == SZ_ADDR)
                    begin
                        // Low word first, high word next
                        n.mem_req  = 1'b1;
                        n.mem_addr = q.mem_addr + HI_WORD_STEP;
                        n.state    = ST_SRCHI;
                    end
                    else
                        n.state = ST_DSTGO;
                end
            end
            ST_SRCHI:
            begin
                if (MEM_ACK)
                begin
                    n.src     = {MEM_RDATA[3:0], q.src[15:0]};
                    n.mem_req = 1'b0;
                    n.state   = ST_DSTGO;
                end
            end
            ST_DSTGO:
            begin
                if (has_src && q.smode == M_INC && q.sreg != REG_PC)
                begin
                    n.rf_we    = 1'b1;
                    n.rf_waddr = q.sreg;
                    n.rf_wdata = s_base + step_of(q.size);
                end
                if (q.op == OP_JMP || q.op == OP_WMOV)
                    n.state = ST_EXEC;
                else if (q.dmode == M_REG)
                begin
                    n.dst   = d_base;
                    n.state = ST_EXEC;
                end
                else
                begin
                    n.mem_req  = 1'b1;
                    n.mem_we   = 1'b0;
                    n.mem_byte = q.size == SZ_BYTE;
                    n.mem_addr = q.daddr;
                    n.state    = ST_DSTLO;
                end
            end
            ST_DSTLO:
            begin
                if (MEM_ACK)
                begin
                    n.dst     = {4'h0, MEM_RDATA};
                    n.mem_req = 1'b0;
                    if (q.size == SZ_ADDR)
                    begin
                        n.mem_req  = 1'b1;
                        n.mem_addr = q.mem_addr + HI_WORD_STEP;
                        n.state    = ST_DSTHI;
                    end
                    else
                        n.state = ST_EXEC;
                end
            end
            ST_DSTHI:
            begin
                if (MEM_ACK)
                begin
                    n.dst     = {MEM_RDATA[3:0], q.dst[15:0]};
                    n.mem_req = 1'b0;
                    n.state   = ST_EXEC;
                end
            end
            ST_EXEC:
            begin
                unique case (q.op)
                    OP_SUBC, OP_WADD:
                    begin
                        if (q.op == OP_SUBC)
                            sum = {1'b0, q.dst & m} + {1'b0, ~q.src & m} + {20'h00000, q.sr[SR_C]};
                        else
                            sum = {1'b0, q.dst} + {1'b0, q.src};
                        r   = sum[19:0] & m;
                        fc  = carry_of(sum, q.size);
                        if (q.op == OP_SUBC)
                            fv = (msb_of(q.src, q.size) != msb_of(q.dst, q.size))
                               && (msb_of(r, q.size) != msb_of(q.dst, q.size));
                        else
                            fv = (msb_of(q.src, q.size) == msb_of(q.dst, q.size))
                               && (msb_of(r, q.size) != msb_of(q.dst, q.size));
                        upd = 1'b1;
                    end
                    OP_SWPB:
                    begin
                        // High nibble kept at address-word size only
                        r = {(q.size == SZ_ADDR) ? q.dst[19:16] : 4'h0, q.dst[7:0], q.dst[15:8]};
                    end
                    OP_SXT:
                    begin
                        if (q.dmode == M_REG || q.size == SZ_ADDR)
                            r = {{12{q.dst[7]}}, q.dst[7:0]};
                        else
                            r = {4'h0, {8{q.dst[7]}}, q.dst[7:0]};
                        fc  = (r & m) != 20'h00000;
                        upd = 1'b1;
                    end
                    OP_TST:
                    begin
                        sum = {1'b0, q.dst & m} + {1'b0, m} + 21'h000001;
                        r   = sum[19:0] & m;
                        fc  = 1'b1;
                        upd = 1'b1;
                    end
                    OP_XOR:
                    begin
                        r   = (q.src ^ q.dst) & m;
                        fc  = r != 20'h00000;
                        fv  = msb_of(q.src, q.size) && msb_of(q.dst, q.size);
                        upd = 1'b1;
                    end
                    default:
                    begin
                        r = q.src;
                    end
                endcase
                if (upd)
                begin
                    // Only arithmetic flags move
                    n.sr[SR_N] = msb_of(r, q.size);
                    n.sr[SR_Z] = (r & m) == 20'h00000;
                    n.sr[SR_C] = fc;
                    n.sr[SR_V] = fv;
                end
                n.res = r;
                if (q.op == OP_JMP)
                begin
                    n.pc    = q.src;
                    n.done  = 1'b1;
                    n.ready = 1'b1;
                    n.state = ST_IDLE;
                end
                else if (!wr_dst)
                begin
                    n.done  = 1'b1;
                    n.ready = 1'b1;
                    n.state = ST_IDLE;
                end
                else if (q.dmode == M_REG)
                begin
                    if (q.dreg == REG_PC)
                        n.pc = r;
                    else if (q.dreg != REG_SR && q.dreg != REG_CG)
                    begin
                        n.rf_we    = 1'b1;
                        n.rf_waddr = q.dreg;
                        n.rf_wdata = r;
                    end
                    n.done  = 1'b1;
                    n.ready = 1'b1;
                    n.state = ST_IDLE;
                end
                else
                begin
                    n.mem_req   = 1'b1;
                    n.mem_we    = 1'b1;
                    n.mem_byte  = q.size == SZ_BYTE;
                    n.mem_addr  = q.daddr;
                    n.mem_wdata = (q.size == SZ_BYTE) ? {8'h00, r[7:0]} : r[15:0];
                    n.state     = ST_WRLO;
                end
            end
            ST_WRLO:
            begin
                if (MEM_ACK)
                begin
                    n.mem_req = 1'b0;
                    n.mem_we  = 1'b0;
                    if (q.size == SZ_ADDR)
                    begin
                        // Upper word carries bits 19:16, bits 31:20 cleared
                        n.mem_req   = 1'b1;
                        n.mem_we    = 1'b1;
                        n.mem_addr  = q.mem_addr + HI_WORD_STEP;
                        n.mem_wdata = {12'h000, q.res[19:16]};
                        n.state     = ST_WRHI;
                    end
                    else
                    begin
                        n.done  = 1'b1;
                        n.ready = 1'b1;
                        n.state = ST_IDLE;
                    end
                end
            end
            ST_WRHI:
            begin
                if (MEM_ACK)
                begin
                    n.mem_req = 1'b0;
                    n.mem_we  = 1'b0;
                    n.done    = 1'b1;
                    n.ready   = 1'b1;
                    n.state   = ST_IDLE;
                end
            end
            default:
            begin
                n.state = ST_IDLE;
            end
        endcase
    end

    //--------------------------------------------------------------------------
    // State register
    //--------------------------------------------------------------------------
    always_ff @(posedge REF_CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            q       <= '0;
            q.state <= ST_IDLE;
            q.size  <= SZ_ADDR;
            q.pc    <= PC_RESET;
            q.sr    <= SR_RESET;
            q.ready <= 1'b1;
        end
        else
        begin
            q <= n;
        end
    end

    //--------------------------------------------------------------------------
    // Outputs
    //--------------------------------------------------------------------------
    assign OP_READY   = q.ready;
    assign OP_DONE    = q.done;
    assign RESULT     = q.res;
    assign PC_VALUE   = q.pc;
    assign STATUS_REG = q.sr;
    assign MEM_REQ    = q.mem_req;
    assign MEM_WE     = q.mem_we;
    assign MEM_BYTE   = q.mem_byte;
    assign MEM_ADDR   = q.mem_addr;
    assign MEM_WDATA  = q.mem_wdata;

endmodule // xal_core
`default_nettype wire

/* verification/xal_checker.sv */
// Port checker for the extended ALU datapath
`timescale 1ns/1ns
`default_nettype none
module xal_checker
    import xal_pkg::*;
(
    input wire logic        REF_CLK,
    input wire logic        RST_N,
    input wire logic        OP_VALID,
    input wire logic        OP_READY,
    input wire logic        OP_DONE,
    input wire logic [3:0]  OP_CODE,
    input wire logic [19:0] PC_VALUE,
    input wire logic [15:0] STATUS_REG,
    input wire logic        MEM_REQ,
    input wire logic        MEM_ACK,
    input wire logic [19:0] MEM_ADDR
);
    logic [3:0] op_q;
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);
    sequence taken_s; OP_VALID && OP_READY; endsequence
    sequence quiet_s; !OP_DONE [*3]; endsequence
    always_ff @(posedge REF_CLK)
        if (OP_VALID && OP_READY) op_q <= OP_CODE;
    ready_drop_a: assert property (taken_s |=> !OP_READY) else $error("ready stayed high");
    done_time_a: assert property (taken_s |=> quiet_s ##[1:300] OP_DONE) else $error("done late");
    done_pulse_a: assert property (OP_DONE |=> !OP_DONE) else $error("done too long");
    req_hold_a: assert property (MEM_REQ && !MEM_ACK |=> MEM_REQ && $stable(MEM_ADDR)) else $error("req dropped");
    pc_change_a: assert property ($changed(PC_VALUE) |-> OP_DONE) else $error("pc moved early");
    sr_change_a: assert property ($changed(STATUS_REG) |-> !OP_READY || OP_DONE) else $error("flags moved");
    swap_flags_a: assert property (OP_DONE && op_q == OP_SWPB |-> $stable(STATUS_REG)) else $error("swap flags");
    test_flags_a: assert property (OP_DONE && op_q == OP_TST |-> STATUS_REG[SR_C] && !STATUS_REG[SR_V])
        else $error("test flags");
    mode_bits_a: assert property (STATUS_REG[SR_OSCSTP:SR_IEN] == 3'h0) else $error("mode bits set");
endmodule // xal_checker
bind xal_core xal_checker u_chk (.REF_CLK(REF_CLK), .RST_N(RST_N), .OP_VALID(OP_VALID), .OP_READY(OP_READY),
    .OP_DONE(OP_DONE), .OP_CODE(OP_CODE), .PC_VALUE(PC_VALUE), .STATUS_REG(STATUS_REG), .MEM_REQ(MEM_REQ),
    .MEM_ACK(MEM_ACK), .MEM_ADDR(MEM_ADDR));
`default_nettype wire

/* verification/xal_mem_model.sv */
// Memory answering reads after a set latency
`timescale 1ns/1ns
`default_nettype none
module xal_mem_model
(
    input  wire logic        clk,
    input  wire logic [1:0]  lat,
    input  wire logic        req,
    input  wire logic [19:0] addr,
    output logic             ack,
    output logic [15:0]      rdata
);
    logic [1:0]  wait_cnt = 2'h0;
    logic [15:0] noise    = 16'h0000;
    always @(posedge clk)
    begin
        ack <= 1'b0;
        noise <= noise + 16'h9e37;
        if (req && !ack)
        begin
            wait_cnt <= (wait_cnt == lat) ? 2'h0 : wait_cnt + 2'h1;
            ack <= (wait_cnt == lat);
        end
    end
    // Each word holds its inverted address; bus churns between answers
    assign rdata = ack ? ~addr[15:0] : noise;
endmodule // xal_mem_model
`default_nettype wire

/* verification/extended_alu_and_address_ops_tb_top.sv */
// Self-checking bench for the extended ALU datapath
`timescale 1ns/1ns
`default_nettype none
module extended_alu_and_address_ops_tb_top
    import xal_pkg::*;
;
    logic clk = 1'b0, rst_n = 1'b0, v = 1'b0, rdy, done, req, we, mb, ack;
    logic [3:0] code = 4'h0, srg = 4'h0, drg = 4'h0;
    logic [1:0] sz = 2'h0, lat = 2'h0;
    logic [2:0] sm = 3'h0, dm = 3'h0;
    logic [15:0] si = 16'h0000, st, rd, wd;
    logic [19:0] simm = 20'h0, res, pc, ma;
    int error_cnt = 0, samples_checked = 0;
    always #5 clk = ~clk;
    xal_core dut (.REF_CLK(clk), .RST_N(rst_n), .OP_VALID(v), .OP_CODE(code), .OP_SIZE(sz), .SRC_MODE(sm),
        .SRC_REG(srg), .SRC_IMM(simm), .SRC_INDEX(si), .DST_MODE(dm), .DST_REG(drg), .DST_IMM(simm),
        .DST_INDEX(16'h0000), .OP_READY(rdy), .OP_DONE(done), .RESULT(res), .PC_VALUE(pc), .STATUS_REG(st),
        .MEM_REQ(req), .MEM_WE(we), .MEM_BYTE(mb), .MEM_ADDR(ma), .MEM_WDATA(wd), .MEM_ACK(ack), .MEM_RDATA(rd));
    xal_mem_model mem (.clk(clk), .lat(lat), .req(req), .addr(ma), .ack(ack), .rdata(rd));
    task automatic op(input logic [3:0] c, input logic [1:0] z, input logic [2:0] smd, input logic [3:0] sr,
                      input logic [19:0] imm, input logic [3:0] dr);
        int n;
        @(negedge clk);
        {code, sz, sm, srg, simm, drg} = {c, z, smd, sr, imm, dr};
        v = 1'b1;
        @(negedge clk);
        v = 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 400)
        begin
            @(negedge clk);
            n++;
        end
        chk({19'h0, done}, 20'h00001);
    endtask
    task automatic chk(input logic [19:0] got, input logic [19:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic t_swap();
        op(4'h7, SZ_ADDR, M_IMM, 4'h0, 20'h23456, 4'h5);
        op(OP_SWPB, SZ_WORD, M_REG, 4'h0, 20'h0, 4'h5);
        chk(res, 20'h05634);
        op(4'h7, SZ_ADDR, M_IMM, 4'h0, 20'h23456, 4'h5);
        op(OP_SWPB, SZ_ADDR, M_REG, 4'h0, 20'h0, 4'h5);
        chk(res, 20'h25634);
        chk({4'h0, st}, 20'h00103);
    endtask
    task automatic t_arith();
        op(4'h7, SZ_ADDR, M_IMM, 4'h0, 20'h00005, 4'h6);
        op(OP_SUBC, SZ_WORD, M_IMM, 4'h0, 20'h00003, 4'h6);
        chk(res, 20'h00001);
        chk({4'h0, st}, 20'h00001);
        op(OP_XOR, SZ_WORD, M_IMM, 4'h0, 20'h00001, 4'h6);
        chk(res, 20'h00000);
        chk({4'h0, st}, 20'h00002);
        op(4'h7, SZ_ADDR, M_IMM, 4'h0, 20'h000a5, 4'h8);
        op(OP_SXT, SZ_ADDR, M_REG, 4'h0, 20'h0, 4'h8);
        chk(res, 20'hfffa5);
        chk({4'h0, st}, 20'h00005);
        op(OP_TST, SZ_BYTE, M_REG, 4'h0, 20'h0, 4'h6);
        chk({4'h0, st}, 20'h00003);
        op(4'h7, SZ_ADDR, M_IMM, 4'h0, 20'h80000, 4'h9);
        op(4'h5, SZ_ADDR, M_IMM, 4'h0, 20'h80000, 4'h9);
        chk(res, 20'h00000);
        chk({4'h0, st}, 20'h00103);
    endtask
    task automatic t_jump();
        op(4'h6, SZ_ADDR, M_ABS, 4'h0, 20'h00100, 4'h0);
        chk(pc, 20'hdfeff);
        dm = M_ABS;
        op(OP_SXT, SZ_ADDR, M_REG, 4'h0, 20'h00300, 4'h0);
        dm = M_REG;
        chk(res, 20'hfffff);
        chk({4'h0, wd}, 20'h0000f);
        chk(ma, 20'h00302);
        lat = 2'h2;
        op(4'h7, SZ_ADDR, M_IMM, 4'h0, 20'h00200, 4'h7);
        op(4'h6, SZ_ADDR, M_INC, 4'h7, 20'h0, 4'h0);
        chk(pc, 20'hdfdff);
        op(4'h5, SZ_ADDR, M_IMM, 4'h0, 20'h0, 4'h7);
        chk(res, 20'h00204);
        si = 16'hfffe;
        op(4'h6, SZ_ADDR, M_IDX, 4'h7, 20'h0, 4'h0);
        chk(pc, 20'hbfdfd);
        op(4'h6, SZ_ADDR, M_SYM, 4'h0, 20'h0, 4'h0);
        chk(pc, 20'h20204);
    endtask
    task automatic final_report();
        $display("checked %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        #100000;
        error_cnt++;
        $display("[FAIL] %0t watchdog", $time);
        final_report();
    end
    initial
    begin
        repeat (8) @(posedge clk);
        @(negedge clk) rst_n = 1'b1;
        repeat (3) @(negedge clk);
        t_arith();
        t_swap();
        t_jump();
        final_report();
    end
endmodule // extended_alu_and_address_ops_tb_top
`default_nettype wire
